/* adst_cap_model.sv */
// Downstream capture logic model for the two output buses.
// Assumes the core clock; readyMode 0 always ready, 1 stalls one cycle in three, 2 never ready.
`default_nettype none

module adst_cap_model
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] doutA,
  input wire logic [7:0] doutB,
  input wire logic doutValid,
  input wire logic doutOeNA,
  input wire logic [1:0] readyMode,
  output logic captureReady,
  output logic [15:0] word,
  output logic take
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] lastW;
  logic [1:0] ph;

  // A released bus shows the inverse of its last level instead of holding it.
  assign word = doutOeNA ? ~lastW : {doutB, doutA};
  assign take = doutValid && captureReady;

  always_ff @(posedge core_clk)
  begin
    ph <= (!nrst || ph == 2'h2) ? 2'h0 : ph + 2'h1;
    lastW <= !nrst ? 16'h0000 : (doutOeNA ? lastW : {doutB, doutA});
    captureReady <= nrst && (readyMode == 2'h0 || (readyMode == 2'h1 && ph != 2'h0));
  end
endmodule

`default_nettype wire

/* adst_chk.sv */
// Port checker for the converter datapath self-test block.
// Assumes it is bound into adst_self_test and sees only its ports.
`default_nettype none

module adst_chk
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic oeBarPin,
  input wire logic spiCsN,
  input wire logic spiSdioOeN,
  input wire logic captureReady,
  input wire logic [7:0] doutA,
  input wire logic [7:0] doutB,
  input wire logic doutValid,
  input wire logic doutOeNA,
  input wire logic doutOeNB
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] upCnt_r;
  logic [3:0] csCnt_r;

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      upCnt_r <= 4'h0;
    else if (upCnt_r != 4'hF)
      upCnt_r <= upCnt_r + 4'h1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst || !spiCsN)
      csCnt_r <= 4'h0;
    else if (csCnt_r != 4'hF)
      csCnt_r <= csCnt_r + 4'h1;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  property p_oeFollow;
    upCnt_r > 4'h5 && $past(oeBarPin, 1) == oeBarPin && $past(oeBarPin, 2) == oeBarPin
      && $past(oeBarPin, 3) == oeBarPin |-> doutOeNA == oeBarPin;
  endproperty
  a_oeFollow: assert property (p_oeFollow) else $error("output enable does not follow pin");
  property p_oeBoth;
    doutOeNA == doutOeNB;
  endproperty
  a_oeBoth: assert property (p_oeBoth) else $error("bus enables differ");
  property p_hold;
    doutValid && !captureReady |=> doutValid && $stable({doutB, doutA});
  endproperty
  a_hold: assert property (p_hold) else $error("word not held while stalled");
  property p_rstVal;
    disable iff (1'b0) !nrst |=> !doutValid && doutOeNA && doutOeNB && doutA == 8'h00;
  endproperty
  a_rstVal: assert property (p_rstVal) else $error("outputs not at reset values");
  property p_dropOk;
    $fell(doutValid) |-> $past(captureReady);
  endproperty
  a_dropOk: assert property (p_dropOk) else $error("valid dropped without accept");
  property p_sdioOff;
    csCnt_r > 4'h5 |-> spiSdioOeN;
  endproperty
  a_sdioOff: assert property (p_sdioOff) else $error("serial data driven while deselected");
  // The end of a self-test run leaves one empty cycle in the stream, never two in a row.
  property p_flow;
    (captureReady [*4]) ##0 upCnt_r == 4'hF |-> doutValid || $past(doutValid);
  endproperty
  a_flow: assert property (p_flow) else $error("stream stopped while clocked");
  property p_relVal;
    $rose(nrst) |-> doutOeNA && !doutValid;
  endproperty
  a_relVal: assert property (p_relVal) else $error("outputs active at reset release");

  c_accept: cover property (doutValid && captureReady);
  c_stall: cover property (doutValid && !captureReady ##1 captureReady);
  c_read: cover property ($fell(spiSdioOeN));
  c_tri: cover property ($rose(doutOeNA));
endmodule

bind adst_self_test adst_chk i_chk (.core_clk(core_clk), .nrst(nrst), .oeBarPin(oeBarPin),
  .spiCsN(spiCsN), .spiSdioOeN(spiSdioOeN), .captureReady(captureReady), .doutA(doutA),
  .doutB(doutB), .doutValid(doutValid), .doutOeNA(doutOeNA), .doutOeNB(doutOeNB));

`default_nettype wire

/* adst_fifo.sv */
// Synchronous FIFO in flip-flops with valid/ready on both sides.
// Assumes the stream interface and a synchronous active-low reset.
`default_nettype none

module adst_fifo #(parameter int W = 16, parameter int D = 16)
(
  input wire logic core_clk,
  input wire logic nrst,
  adst_stream_if.snk fillS,
  adst_stream_if.src drainS
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] FULL_COUNT = (AW + 1)'(D);
  localparam logic [AW-1:0] LAST_PTR = AW'(D - 1);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  assign fillS.ready = (count_r != FULL_COUNT);
  assign drainS.valid = (count_r != '0);
  assign drainS.data = mem[rdPtr_r];
  assign push = fillS.valid && fillS.ready;
  assign pop = drainS.valid && drainS.ready;

  always_ff @(posedge core_clk)
  begin
    if (push)
    begin
      mem[wrPtr_r] <= fillS.data;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wrPtr_r <= (wrPtr_r == LAST_PTR) ? '0 : wrPtr_r + 1'b1;
      end
      if (pop)
      begin
        rdPtr_r <= (rdPtr_r == LAST_PTR) ? '0 : rdPtr_r + 1'b1;
      end
      if (push && !pop)
      begin
        count_r <= count_r + 1'b1;
      end
      else if (pop && !push)
      begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

/* adst_pkg.sv */
// Constants, register map and helper functions for the converter datapath self-test block.
// Assumes one core clock domain and an 8-bit register space reached over the serial port.
`default_nettype none

package adst_pkg;

  localparam int LANE_W = 8;
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 16;

  localparam logic [12:0] ADDR_TEST_MODE = 13'h000D;
  localparam logic [12:0] ADDR_SELF_TEST = 13'h000E;
  localparam logic [7:0] TEST_MODE_RESET = 8'h00;

  localparam int TM_MODE_LSB = 0;
  localparam int TM_PNL_RST_BIT = 4;
  localparam int TM_PNS_RST_BIT = 5;
  localparam int ST_RUN_BIT = 0;
  localparam int ST_RESTART_BIT = 2;

  localparam logic [3:0] TM_OFF = 4'h0;
  localparam logic [3:0] TM_MIDSCALE = 4'h1;
  localparam logic [3:0] TM_POS_FS = 4'h2;
  localparam logic [3:0] TM_NEG_FS = 4'h3;
  localparam logic [3:0] TM_CHECKER = 4'h4;
  localparam logic [3:0] TM_PN_LONG = 4'h5;
  localparam logic [3:0] TM_PN_SHORT = 4'h6;
  localparam logic [3:0] TM_TOGGLE = 4'h7;

  localparam logic [7:0] PAT_MIDSCALE = 8'h80;
  localparam logic [7:0] PAT_POS_FS = 8'hFF;
  localparam logic [7:0] PAT_NEG_FS = 8'h00;
  localparam logic [7:0] PAT_CHECK_A = 8'h55;
  localparam logic [7:0] PAT_CHECK_B = 8'hAA;
  localparam logic [7:0] PAT_TOGGLE_A = 8'h00;
  localparam logic [7:0] PAT_TOGGLE_B = 8'hFF;

  localparam logic [1:0] FMT_OFFSET = 2'h0;
  localparam logic [1:0] FMT_TWOS = 2'h1;
  localparam logic [1:0] FMT_GRAY = 2'h2;

  localparam int BIST_WORDS = 512;
  localparam logic [9:0] BIST_COUNT = 10'h200;
  localparam logic [9:0] BIST_LAST = 10'h1FF;
  localparam logic [15:0] BIST_SEED = 16'hACE1;
  localparam logic [15:0] BIST_TAPS = 16'hB400;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [22:0] PNL_SEED = 23'h7FFFFF;
  localparam logic [8:0] PNS_SEED = 9'h1FF;

  localparam logic [4:0] INSTR_LAST = 5'h0F;
  localparam logic [4:0] BYTE_LAST = 5'h07;

  typedef enum logic [0:0] {SP_INSTR = 1'b0, SP_DATA = 1'b1} adst_spi_e;

  function automatic logic [15:0] bistNext(input logic [15:0] s);
    return s[0] ? ((s >> 1) ^ BIST_TAPS) : (s >> 1);
  endfunction

  function automatic logic [15:0] crcNext(input logic [15:0] c, input logic [15:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 15; i >= 0; i--)
    begin
      r = (r[15] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // Signature of a full run from the seed, evaluated once at elaboration.
  function automatic logic [15:0] expectedSig();
    logic [15:0] s;
    logic [15:0] c;
    s = BIST_SEED;
    c = CRC_INIT;
    for (int n = 0; n < BIST_WORDS; n++)
    begin
      c = crcNext(c, s);
      s = bistNext(s);
    end
    return c;
  endfunction

  localparam logic [15:0] BIST_SIGNATURE = expectedSig();

endpackage

`default_nettype wire

/* adst_self_test.sv */
// Datapath self-test, output test patterns, output enable and serial register port of the converter back end.
// Assumes converter samples and downstream ready arrive on core_clk; serial pins and the enable pin are async.
`default_nettype none

module adst_self_test
  import adst_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] adcDataA,
  input wire logic [7:0] adcDataB,
  input wire logic [1:0] fmtSel,
  input wire logic oeBarPin,
  input wire logic spiSclk,
  input wire logic spiCsN,
  input wire logic spiSdioIn,
  output logic spiSdioOut,
  output logic spiSdioOeN,
  input wire logic captureReady,
  output logic [7:0] doutA,
  output logic [7:0] doutB,
  output logic doutValid,
  output logic doutOeNA,
  output logic doutOeNB
);

  logic [2:0] sclkSync_r;
  logic [1:0] csSync_r;
  logic [1:0] sdioSync_r;
  logic [1:0] oeSync_r;
  logic sclkRise;
  logic sclkFall;
  logic csActive;
  logic sdioBit;

  adst_spi_e spiState_r;
  logic [4:0] bitCnt_r;
  logic [15:0] shIn_r;
  logic spiRead_r;
  logic [12:0] spiAddr_r;
  logic [7:0] rdShift_r;
  logic [15:0] instrWord;
  logic [12:0] rdAddr;
  logic [7:0] rdData;
  logic [7:0] wrByte;
  logic regWrite;

  logic [7:0] testMode_r;
  logic [3:0] mode;
  logic restart_r;
  logic running_r;
  logic pass_r;
  logic [9:0] issueCnt_r;
  logic [9:0] pushCnt_r;
  logic [15:0] bistLfsr_r;
  logic [15:0] crc_r;
  logic [15:0] crcUpd;
  logic startReq;
  logic bistIssue;
  logic bistPush;

  logic [22:0] pnLong_r;
  logic [8:0] pnShort_r;
  logic phase_r;

  logic [15:0] srcWord;
  logic srcValid;
  logic srcRaw;
  logic srcBist;
  logic dpValid_r;
  logic [15:0] dpWord_r;
  logic dpRaw_r;
  logic dpBist_r;
  logic advance;
  logic push;
  logic [7:0] fmtLane [2];

  adst_stream_if #(.W(WORD_W)) fillIf ();
  adst_stream_if #(.W(WORD_W)) drainIf ();

  function automatic logic [7:0] fmtByte(input logic [7:0] b, input logic [1:0] sel);
    case (sel)
      FMT_TWOS: return {~b[7], b[6:0]};
      FMT_GRAY: return b ^ (b >> 1);
      default: return b;
    endcase
  endfunction

  // Serial pins and the enable pin cross into core_clk through two flip-flops.
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      sclkSync_r <= 3'h0;
      csSync_r <= 2'h3;
      sdioSync_r <= 2'h0;
      oeSync_r <= 2'h3;
    end
    else
    begin
      sclkSync_r <= {sclkSync_r[1:0], spiSclk};
      csSync_r <= {csSync_r[0], spiCsN};
      sdioSync_r <= {sdioSync_r[0], spiSdioIn};
      oeSync_r <= {oeSync_r[0], oeBarPin};
    end
  end

  assign sclkRise = sclkSync_r[1] && !sclkSync_r[2];
  assign sclkFall = !sclkSync_r[1] && sclkSync_r[2];
  assign csActive = !csSync_r[1];
  assign sdioBit = sdioSync_r[1];
  assign instrWord = {shIn_r[14:0], sdioBit};
  assign wrByte = instrWord[7:0];
  assign rdAddr = (spiState_r == SP_INSTR) ? instrWord[12:0] : spiAddr_r - 13'h0001;
  assign regWrite = csActive && sclkRise && (spiState_r == SP_DATA) && (bitCnt_r == BYTE_LAST) && !spiRead_r;

  // Bit 0 reads the run in progress, then the pass result once the run has stopped.
  always_comb
  begin
    rdData = 8'h00;
    if (rdAddr == ADDR_TEST_MODE)
    begin
      rdData = testMode_r;
    end
    else if (rdAddr == ADDR_SELF_TEST)
    begin
      rdData = {5'h00, restart_r, 1'b0, running_r | pass_r};
    end
  end

  // Frame: 16-bit instruction, then bytes at descending addresses until chip select rises.
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      spiState_r <= SP_INSTR;
      bitCnt_r <= 5'h00;
      shIn_r <= 16'h0000;
      spiRead_r <= 1'b0;
      spiAddr_r <= 13'h0000;
      rdShift_r <= 8'h00;
      spiSdioOut <= 1'b0;
      spiSdioOeN <= 1'b1;
    end
    else if (!csActive)
    begin
      spiState_r <= SP_INSTR;
      bitCnt_r <= 5'h00;
      spiSdioOeN <= 1'b1;
    end
    else if (sclkRise)
    begin
      shIn_r <= instrWord;
      case (spiState_r)
        SP_INSTR:
        begin
          if (bitCnt_r == INSTR_LAST)
          begin
            spiRead_r <= instrWord[15];
            spiAddr_r <= instrWord[12:0];
            spiState_r <= SP_DATA;
            bitCnt_r <= 5'h00;
            rdShift_r <= rdData;
          end
          else
          begin
            bitCnt_r <= bitCnt_r + 5'h01;
          end
        end
        default:
        begin
          if (bitCnt_r == BYTE_LAST)
          begin
            bitCnt_r <= 5'h00;
            spiAddr_r <= rdAddr;
            rdShift_r <= rdData;
          end
          else
          begin
            bitCnt_r <= bitCnt_r + 5'h01;
          end
        end
      endcase
    end
    else if (sclkFall && (spiState_r == SP_DATA) && spiRead_r)
    begin
      spiSdioOut <= rdShift_r[7];
      rdShift_r <= {rdShift_r[6:0], 1'b0};
      spiSdioOeN <= 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      testMode_r <= TEST_MODE_RESET;
    end
    else if (regWrite && (spiAddr_r == ADDR_TEST_MODE))
    begin
      testMode_r <= wrByte;
    end
  end

  assign mode = testMode_r[TM_MODE_LSB +: 4];
  assign startReq = regWrite && (spiAddr_r == ADDR_SELF_TEST) && wrByte[ST_RUN_BIT] && !running_r;
  assign bistIssue = running_r && advance && (issueCnt_r != BIST_COUNT);
  assign bistPush = push && dpBist_r;
  assign crcUpd = crcNext(crc_r, dpWord_r);

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      restart_r <= 1'b0;
    end
    else if (regWrite && (spiAddr_r == ADDR_SELF_TEST))
    begin
      restart_r <= wrByte[ST_RESTART_BIT];
    end
  end

  // Run control: count issued and arrived words, then judge the signature.
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      running_r <= 1'b0;
      pass_r <= 1'b0;
      issueCnt_r <= 10'h000;
      pushCnt_r <= 10'h000;
      crc_r <= CRC_INIT;
    end
    else if (startReq)
    begin
      running_r <= 1'b1;
      pass_r <= 1'b0;
      issueCnt_r <= 10'h000;
      pushCnt_r <= 10'h000;
      crc_r <= CRC_INIT;
    end
    else if (running_r)
    begin
      if (bistIssue)
      begin
        issueCnt_r <= issueCnt_r + 10'h001;
      end
      if (bistPush)
      begin
        crc_r <= crcUpd;
        pushCnt_r <= pushCnt_r + 10'h001;
        if (pushCnt_r == BIST_LAST)
        begin
          running_r <= 1'b0;
          pass_r <= (crcUpd == BIST_SIGNATURE);
        end
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      bistLfsr_r <= BIST_SEED;
    end
    else if (startReq && wrByte[ST_RESTART_BIT])
    begin
      bistLfsr_r <= BIST_SEED;
    end
    else if (bistIssue)
    begin
      bistLfsr_r <= bistNext(bistLfsr_r);
    end
  end

  // Sequence generators are held at their seed while their reset bit is set.
  always_ff @(posedge core_clk)
  begin
    if (!nrst || testMode_r[TM_PNL_RST_BIT])
    begin
      pnLong_r <= PNL_SEED;
    end
    else if (advance && (mode == TM_PN_LONG))
    begin
      pnLong_r <= {pnLong_r[21:0], pnLong_r[22] ^ pnLong_r[17]};
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst || testMode_r[TM_PNS_RST_BIT])
    begin
      pnShort_r <= PNS_SEED;
    end
    else if (advance && (mode == TM_PN_SHORT))
    begin
      pnShort_r <= {pnShort_r[7:0], pnShort_r[8] ^ pnShort_r[4]};
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      phase_r <= 1'b0;
    end
    else if (advance)
    begin
      phase_r <= !phase_r;
    end
  end

  // Source select: self-test words first, then a test pattern, else converter samples.
  always_comb
  begin
    srcWord = {adcDataB, adcDataA};
    srcValid = 1'b1;
    srcRaw = 1'b0;
    srcBist = 1'b0;
    if (running_r)
    begin
      srcWord = bistLfsr_r;
      srcValid = (issueCnt_r != BIST_COUNT);
      srcRaw = 1'b1;
      srcBist = 1'b1;
    end
    else
    begin
      case (mode)
        TM_OFF: srcWord = {adcDataB, adcDataA};
        TM_MIDSCALE: srcWord = {PAT_MIDSCALE, PAT_MIDSCALE};
        TM_POS_FS: srcWord = {PAT_POS_FS, PAT_POS_FS};
        TM_NEG_FS: srcWord = {PAT_NEG_FS, PAT_NEG_FS};
        TM_CHECKER:
        begin
          srcWord = phase_r ? {PAT_CHECK_B, PAT_CHECK_B} : {PAT_CHECK_A, PAT_CHECK_A};
          srcRaw = 1'b1;
        end
        TM_PN_LONG:
        begin
          srcWord = {pnLong_r[7:0], pnLong_r[7:0]};
          srcRaw = 1'b1;
        end
        TM_PN_SHORT:
        begin
          srcWord = {pnShort_r[7:0], pnShort_r[7:0]};
          srcRaw = 1'b1;
        end
        TM_TOGGLE:
        begin
          srcWord = phase_r ? {PAT_TOGGLE_B, PAT_TOGGLE_B} : {PAT_TOGGLE_A, PAT_TOGGLE_A};
          srcRaw = 1'b1;
        end
        default: srcWord = {adcDataB, adcDataA};
      endcase
    end
  end

  // A full buffer stalls this stage; converter samples arriving then are lost.
  assign advance = !dpValid_r || fillIf.ready;
  assign push = dpValid_r && fillIf.ready;

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      dpValid_r <= 1'b0;
      dpWord_r <= 16'h0000;
      dpRaw_r <= 1'b0;
      dpBist_r <= 1'b0;
    end
    else if (advance)
    begin
      dpValid_r <= srcValid;
      dpWord_r <= srcWord;
      dpRaw_r <= srcRaw;
      dpBist_r <= srcBist;
    end
  end

  for (genvar g = 0; g < 2; g++)
  begin : g_lane
    assign fmtLane[g] = dpRaw_r ? dpWord_r[g*LANE_W +: LANE_W] : fmtByte(dpWord_r[g*LANE_W +: LANE_W], fmtSel);
  end

  assign fillIf.valid = dpValid_r;
  assign fillIf.data = {fmtLane[1], fmtLane[0]};

  adst_fifo #(.W(WORD_W), .D(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .nrst(nrst),
    .fillS(fillIf.snk),
    .drainS(drainIf.src)
  );

  assign drainIf.ready = !doutValid || captureReady;

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      doutValid <= 1'b0;
      doutA <= 8'h00;
      doutB <= 8'h00;
    end
    else if (drainIf.ready)
    begin
      doutValid <= drainIf.valid;
      if (drainIf.valid)
      begin
        doutA <= drainIf.data[7:0];
        doutB <= drainIf.data[15:8];
      end
    end
  end

  // Only reset and the enable pin tri-state the buses; a self-test run keeps them driven.
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      doutOeNA <= 1'b1;
      doutOeNB <= 1'b1;
    end
    else
    begin
      doutOeNA <= oeSync_r[1];
      doutOeNB <= oeSync_r[1];
    end
  end

endmodule

`default_nettype wire

/* adst_stream_if.sv */
// Valid/ready word stream between the datapath and its output buffer.
// Assumes both ends run on the same core clock.
`default_nettype none

interface adst_stream_if #(parameter int W = 16);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface

`default_nettype wire

/* tb.sv */
// Testbench: serial-port driven checks of test modes, output enable and self-test runs.
// Assumes the checker and capture model are compiled before it.
`default_nettype none

module tb
  import adst_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0, nrst = 1'b0, oeBar = 1'b0, sclk = 1'b0, csN = 1'b1, tbSdio = 1'b0;
  logic [7:0] adcA = 8'h00, adcB = 8'h00;
  logic [1:0] fmt = 2'h0, rdy = 2'h0;
  logic sdoOut, sdoOeN, capRdy, doutValid, oeNA, oeNB, take, sdioLine;
  logic [7:0] doutA, doutB, a1;
  logic [15:0] word, s;
  logic [15:0] q[$];
  int errors = 0, n_checks = 0, cycles = 0;
  logic [7:0] pats[3] = '{PAT_MIDSCALE, PAT_POS_FS, PAT_NEG_FS};
  logic [3:0] rawM[2] = '{TM_CHECKER, TM_TOGGLE};
  logic [15:0] rawP[2] = '{{PAT_CHECK_A, PAT_CHECK_B}, {PAT_TOGGLE_A, PAT_TOGGLE_B}};
  logic [3:0] pnM[2] = '{TM_PN_LONG, TM_PN_SHORT};
  int pnB[2] = '{TM_PNL_RST_BIT, TM_PNS_RST_BIT};

  assign sdioLine = sdoOeN ? tbSdio : sdoOut;

  adst_self_test i_dut (.core_clk(core_clk), .nrst(nrst), .adcDataA(adcA), .adcDataB(adcB),
    .fmtSel(fmt), .oeBarPin(oeBar), .spiSclk(sclk), .spiCsN(csN), .spiSdioIn(sdioLine),
    .spiSdioOut(sdoOut), .spiSdioOeN(sdoOeN), .captureReady(capRdy), .doutA(doutA),
    .doutB(doutB), .doutValid(doutValid), .doutOeNA(oeNA), .doutOeNB(oeNB));
  adst_cap_model i_cap (.core_clk(core_clk), .nrst(nrst), .doutA(doutA), .doutB(doutB),
    .doutValid(doutValid), .doutOeNA(oeNA), .readyMode(rdy), .captureReady(capRdy),
    .word(word), .take(take));

  initial
  begin
    forever #2.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    if (take)
      q.push_back(word);
    cycles++;
    if (cycles == 60000)
    begin
      errors++;
      report_and_stop();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic rw, input logic [12:0] a, input logic [7:0] d, output logic [7:0] r);
    logic [23:0] v;
    v = {rw, 2'b00, a, d};
    csN <= 1'b0;
    cyc(6);
    for (int i = 23; i >= 0; i--)
    begin
      sclk <= 1'b0;
      tbSdio <= (rw && i < 8) ? ~tbSdio : v[i];
      cyc(6);
      r = {r[6:0], sdioLine};
      sclk <= 1'b1;
      cyc(6);
    end
    sclk <= 1'b0;
    cyc(6);
    csN <= 1'b1;
    cyc(8);
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] r;
    xfer(1'b0, a, d, r);
  endtask

  task automatic rdChk(input logic [12:0] a, input logic [7:0] e);
    logic [7:0] r;
    xfer(1'b1, a, 8'h00, r);
    chk({8'h00, r}, {8'h00, e});
  endtask

  function automatic logic [7:0] fmtF(input logic [7:0] b, input logic [1:0] f);
    return (f == 2'h1) ? {~b[7], b[6:0]} : ((f == 2'h2) ? (b ^ (b >> 1)) : b);
  endfunction

  task automatic runChk();
    int i0;
    i0 = -1;
    foreach (q[i])
      if (i0 < 0 && q[i] === s)
        i0 = i;
    for (int k = 0; k < 512; k++)
    begin
      chk(q[i0 + k], s);
      s = s[0] ? ((s >> 1) ^ BIST_TAPS) : (s >> 1);
    end
    chk(q[i0 + 512], 16'h0000);
  endtask

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    cyc(16);
    nrst <= 1'b1;
    cyc(4);
    rdChk(ADDR_TEST_MODE, TEST_MODE_RESET);
    wr(13'h0005, 8'hFF);
    rdChk(13'h0005, 8'h00);
    for (int m = 0; m < 3; m++)
    begin
      wr(ADDR_TEST_MODE, 8'(m + 1));
      for (int f = 0; f < 4; f++)
      begin
        fmt <= 2'(f);
        adcA <= 8'(m * 37 + f);
        cyc(12);
        chk({doutB, doutA}, {2{fmtF(pats[m], 2'(f))}});
      end
    end
    for (int j = 0; j < 2; j++)
    begin
      wr(ADDR_TEST_MODE, {4'h0, rawM[j]});
      cyc(12);
      a1 = doutA;
      cyc(1);
      chk({a1, doutA}, (a1 === rawP[j][15:8]) ? rawP[j] : {rawP[j][7:0], rawP[j][15:8]});
    end
    for (int j = 0; j < 2; j++)
    begin
      wr(ADDR_TEST_MODE, {4'h0, pnM[j]} | (8'h01 << pnB[j]));
      cyc(12);
      a1 = doutA;
      cyc(5);
      chk({a1, doutA}, {2{(j == 0) ? PNL_SEED[7:0] : PNS_SEED[7:0]}});
      wr(ADDR_TEST_MODE, {4'h0, pnM[j]});
      s = 16'h0000;
      repeat (8)
      begin
        cyc(1);
        s[0] = s[0] | (doutA !== a1);
      end
      chk(s, 16'h0001);
    end
    wr(ADDR_TEST_MODE, 8'h00);
    fmt <= 2'h0;
    adcA <= 8'h5A;
    adcB <= 8'hC3;
    cyc(12);
    chk({doutB, doutA}, 16'hC35A);
    rdy <= 2'h2;
    cyc(40);
    chk({15'h0000, doutValid}, 16'h0001);
    rdy <= 2'h0;
    oeBar <= 1'b1;
    cyc(5);
    chk({14'h0000, oeNA, oeNB}, 16'h0003);
    oeBar <= 1'b0;
    adcA <= 8'h00;
    adcB <= 8'h00;
    nrst <= 1'b0;
    cyc(16);
    nrst <= 1'b1;
    cyc(4);
    rdy <= 2'h1;
    q.delete();
    wr(ADDR_SELF_TEST, 8'h05);
    cyc(100);
    chk({15'h0000, oeNA}, 16'h0000);
    cyc(1400);
    rdChk(ADDR_SELF_TEST, 8'h05);
    s = BIST_SEED;
    runChk();
    q.delete();
    wr(ADDR_SELF_TEST, 8'h01);
    cyc(1500);
    rdChk(ADDR_SELF_TEST, 8'h00);
    runChk();
    report_and_stop();
  end
endmodule

`default_nettype wire
